// file: core/bsns_core.sv
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module bsns_core #(
  parameter int BANK_W = bsns_pkg::BANK_W_DEF
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [bsns_pkg::APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Core status
  output logic busy_out
);
  import bsns_pkg::*;

  localparam int ADDR_W = BANK_W + FILE_W;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  bsns_phase_e phase_reg, phase_next;
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic settle_reg, settle_next;
  logic [31:0] prdata_reg, prdata_next;
  logic ext_reg, ext_next;
  logic [7:0] w_reg, w_next;
  logic [BANK_W-1:0] bank_reg, bank_next;
  logic [4:0] status_reg, status_next;
  logic [15:0] instr_reg, instr_next;
  logic [ADDR_W-1:0] madr_reg, madr_next;
  logic [ADDR_W-1:0] idx_reg, idx_next;
  logic [ADDR_W-1:0] ea_reg, ea_next;
  logic bad_reg, bad_next;
  logic subb_reg, subb_next;
  logic dst_reg, dst_next;
  logic [7:0] res_reg, res_next;
  logic [4:0] flag_reg, flag_next;

  // Combinational helpers
  logic apb_done;
  logic hit;
  logic [31:0] rd_mux;
  logic is_subb;
  logic is_swap;
  logic [7:0] fa;
  logic [ADDR_W-1:0] ea_calc;
  logic mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [ADDR_W-1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [7:0] alu_res;
  logic [4:0] alu_flags;

  // ---------------------------------------------------------------
  // File memory and arithmetic unit
  // ---------------------------------------------------------------
  bsns_file_mem #(
    .AW(ADDR_W),
    .DW(FILE_W)
  ) u_mem (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(mem_wdata),
    .raddr_in(mem_raddr),
    .rdata_out(mem_rdata)
  );

  bsns_alu u_alu (
    .subb_in(subb_reg),
    .file_in(mem_rdata),
    .w_in(w_reg),
    .carry_in(status_reg[C_BIT]),
    .result_out(alu_res),
    .flags_out(alu_flags)
  );

  // ---------------------------------------------------------------
  // Decode and address forming
  // ---------------------------------------------------------------
  assign fa = instr_reg[7:0];
  assign is_subb = (instr_reg[15:10] == OPC_SUBB);
  assign is_swap = (instr_reg[15:10] == OPC_SWAP);

  // Effective file address
  always_comb
  begin
    if (instr_reg[A_BIT])
    begin
      ea_calc = {bank_reg, fa};
    end
    else if (ext_reg && (fa <= INDEX_LIMIT))
    begin
      ea_calc = ADDR_W'(idx_reg + ADDR_W'(fa));
    end
    else if (fa < ACCESS_SPLIT)
    begin
      ea_calc = {{BANK_W{1'b0}}, fa};
    end
    else
    begin
      ea_calc = {{BANK_W{1'b1}}, fa};
    end
  end

  // Memory ports: execution drives the read address in PH_READ and the write port in PH_WRITE when dst_reg is set
  always_comb
  begin
    mem_raddr = (phase_reg == PH_READ) ? ea_reg : madr_reg;
    mem_we = 1'b0;
    mem_waddr = madr_reg;
    mem_wdata = pwdata_in[7:0];
    if (phase_reg == PH_WRITE && dst_reg)
    begin
      mem_we = 1'b1;
      mem_waddr = ea_reg;
      mem_wdata = res_reg;
    end
    else if (apb_done && pwrite_in && paddr_in == MDATA_OFS)
    begin
      mem_we = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr_in == CTRL_OFS)
      rd_mux = 32'(ext_reg);
    else if (paddr_in == WREG_OFS)
      rd_mux = 32'(w_reg);
    else if (paddr_in == BANK_OFS)
      rd_mux = 32'(bank_reg);
    else if (paddr_in == STATUS_OFS)
      rd_mux = 32'(status_reg);
    else if (paddr_in == INSTR_OFS)
      rd_mux = 32'(instr_reg);
    else if (paddr_in == EXEC_OFS)
      rd_mux = 32'({bad_reg, busy_out});
    else if (paddr_in == MADDR_OFS)
      rd_mux = 32'(madr_reg);
    else if (paddr_in == MDATA_OFS)
      rd_mux = 32'(mem_rdata);
    else if (paddr_in == IDX_OFS)
      rd_mux = 32'(idx_reg);
    else
      hit = 1'b0;
  end

  // ---------------------------------------------------------------
  // Next state: bus, registers and phase sequencer
  // ---------------------------------------------------------------
  assign apb_done = psel_in && penable_in && ack_reg;

  always_comb
  begin
    phase_next = phase_reg;
    ack_next = 1'b0;
    err_next = err_reg;
    prdata_next = prdata_reg;
    settle_next = (phase_reg != PH_IDLE);
    ext_next = ext_reg;
    w_next = w_reg;
    bank_next = bank_reg;
    status_next = status_reg;
    instr_next = instr_reg;
    madr_next = madr_reg;
    idx_next = idx_reg;
    ea_next = ea_reg;
    bad_next = bad_reg;
    subb_next = subb_reg;
    dst_next = dst_reg;
    res_next = res_reg;
    flag_next = flag_reg;
    // Answer once idle and memory port settled
    if (psel_in && penable_in && !ack_reg && phase_reg == PH_IDLE &&
        !settle_reg)
    begin
      ack_next = 1'b1;
      prdata_next = rd_mux;
      err_next = !hit;
    end
    // Writes take effect at the edge pready is seen
    if (apb_done && pwrite_in)
    begin
      if (paddr_in == CTRL_OFS)
        ext_next = pwdata_in[EXT_BIT];
      else if (paddr_in == WREG_OFS)
        w_next = pwdata_in[7:0];
      else if (paddr_in == BANK_OFS)
        bank_next = pwdata_in[BANK_W-1:0];
      else if (paddr_in == STATUS_OFS)
        status_next = pwdata_in[4:0];
      else if (paddr_in == INSTR_OFS)
      begin
        instr_next = pwdata_in[15:0];
        bad_next = 1'b0;
        phase_next = PH_DECODE;
      end
      else if (paddr_in == MADDR_OFS)
        madr_next = pwdata_in[ADDR_W-1:0];
      else if (paddr_in == IDX_OFS)
        idx_next = pwdata_in[ADDR_W-1:0];
    end
    case (phase_reg)
      PH_DECODE:
      begin
        if (is_subb || is_swap)
        begin
          ea_next = ea_calc;
          subb_next = is_subb;
          dst_next = instr_reg[D_BIT];
          phase_next = PH_READ;
        end
        else
        begin
          bad_next = 1'b1;
          phase_next = PH_IDLE;
        end
      end
      PH_READ:
        phase_next = PH_PROCESS;
      PH_PROCESS:
      begin
        res_next = alu_res;
        flag_next = alu_flags;
        phase_next = PH_WRITE;
      end
      PH_WRITE:
      begin
        // result to W when destination clear
        if (!dst_reg)
          w_next = res_reg;
        if (subb_reg)
          status_next = flag_reg;
        phase_next = PH_IDLE;
      end
      default:
        ;
    endcase
  end

  // Registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      phase_reg <= PH_IDLE;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      settle_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      ext_reg <= 1'b0;
      w_reg <= WREG_RST;
      bank_reg <= '0;
      status_reg <= STATUS_RST;
      instr_reg <= INSTR_RST;
      madr_reg <= '0;
      idx_reg <= '0;
      ea_reg <= '0;
      bad_reg <= 1'b0;
      subb_reg <= 1'b0;
      dst_reg <= 1'b0;
      res_reg <= 8'h00;
      flag_reg <= 5'h00;
    end
    else
    begin
      phase_reg <= phase_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      settle_reg <= settle_next;
      prdata_reg <= prdata_next;
      ext_reg <= ext_next;
      w_reg <= w_next;
      bank_reg <= bank_next;
      status_reg <= status_next;
      instr_reg <= instr_next;
      madr_reg <= madr_next;
      idx_reg <= idx_next;
      ea_reg <= ea_next;
      bad_reg <= bad_next;
      subb_reg <= subb_next;
      dst_reg <= dst_next;
      res_reg <= res_next;
      flag_reg <= flag_next;
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = ack_reg;
  assign pslverr_out = ack_reg & err_reg;
  assign busy_out = (phase_reg != PH_IDLE);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic nc;
  logic [7:0] chk_diff, chk_wrap, chk_swap;
  logic chk_nb, res_zero, res_msb;
  logic [ADDR_W-1:0] chk_bank_ea, chk_idx_ea;
  assign nc = ~status_reg[C_BIT];
  assign chk_diff = 8'(mem_rdata - w_reg - {7'h00, nc});
  assign chk_wrap = 8'(9'h100 + {1'b0, mem_rdata} - {1'b0, w_reg} -
                       {8'h00, nc});
  assign chk_nb = ({1'b0, mem_rdata} >= ({1'b0, w_reg} + {8'h00, nc}));
  assign chk_swap = {mem_rdata[3:0], mem_rdata[7:4]};
  assign res_zero = (res_reg == 8'h00);
  assign res_msb = res_reg[7];
  assign chk_bank_ea = {bank_reg, instr_reg[7:0]};
  assign chk_idx_ea = ADDR_W'(idx_reg + ADDR_W'(instr_reg[7:0]));

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_subb_result: assert property (
    (phase_reg == PH_PROCESS && subb_reg) |=> res_reg == $past(chk_diff))
    else $error("Subtract with borrow result wrong");
  a_swap_result: assert property (
    (phase_reg == PH_PROCESS && !subb_reg) |=>
      (res_reg == $past(chk_swap)) ##1 $stable(status_reg))
    else $error("Nibble swap wrong or flags touched");
  a_dest_w: assert property (
    (phase_reg == PH_WRITE && !dst_reg) |=>
      (w_reg == $past(res_reg)) && !$past(mem_we))
    else $error("Result did not reach W");
  a_dest_file: assert property (
    (phase_reg == PH_WRITE && dst_reg) |->
      mem_we && mem_waddr == ea_reg && mem_wdata == res_reg)
    else $error("Result did not reach file");
  a_bank_addr: assert property (
    (phase_reg == PH_DECODE && instr_reg[A_BIT] && (is_subb || is_swap))
      |=> ea_reg == $past(chk_bank_ea))
    else $error("Banked address wrong");
  a_index_addr: assert property (
    (phase_reg == PH_DECODE && !instr_reg[A_BIT] && ext_reg &&
     instr_reg[7:0] <= INDEX_LIMIT && (is_subb || is_swap))
      |=> ea_reg == $past(chk_idx_ea))
    else $error("Indexed address wrong");
  a_carry_borrow: assert property (
    (phase_reg == PH_PROCESS && subb_reg) |->
      ##2 status_reg[C_BIT] == $past(chk_nb, 2))
    else $error("Carry does not match borrow");
  a_zero_flag: assert property (
    (phase_reg == PH_WRITE && subb_reg) |=>
      status_reg[Z_BIT] == $past(res_zero))
    else $error("Zero flag wrong");
  a_neg_flag: assert property (
    (phase_reg == PH_WRITE && subb_reg) |=>
      status_reg[N_BIT] == $past(res_msb))
    else $error("Negative flag wrong");
  a_wrap_value: assert property (
    (phase_reg == PH_PROCESS && subb_reg && !chk_nb) |=>
      res_reg == $past(chk_wrap))
    else $error("Underflow did not wrap");
  a_phase_order: assert property (
    (phase_reg == PH_DECODE && (is_subb || is_swap)) |=>
      phase_reg == PH_READ ##1 phase_reg == PH_PROCESS
      ##1 phase_reg == PH_WRITE ##1 phase_reg == PH_IDLE)
    else $error("Phase order broken");

  c_subb_to_w: cover property (
    phase_reg == PH_WRITE && subb_reg && !dst_reg);
  c_swap_to_file: cover property (
    phase_reg == PH_WRITE && !subb_reg && dst_reg);
  c_indexed: cover property (
    phase_reg == PH_DECODE && ext_reg && !instr_reg[A_BIT] &&
    instr_reg[7:0] <= INDEX_LIMIT);
  c_underflow: cover property (
    phase_reg == PH_PROCESS && subb_reg && !chk_nb);

endmodule : bsns_core

// file: inc/bsns_pkg.sv
package bsns_pkg;

  // ---------------------------------------------------------------
  // Bus and data widths
  // ---------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam int BANK_W_DEF = 4;
  localparam int FILE_W = 8;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] WREG_OFS = 8'h04;
  localparam logic [7:0] BANK_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] INSTR_OFS = 8'h10;
  localparam logic [7:0] EXEC_OFS = 8'h14;
  localparam logic [7:0] MADDR_OFS = 8'h18;
  localparam logic [7:0] MDATA_OFS = 8'h1c;
  localparam logic [7:0] IDX_OFS = 8'h20;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int C_BIT = 0;
  localparam int DC_BIT = 1;
  localparam int Z_BIT = 2;
  localparam int OV_BIT = 3;
  localparam int N_BIT = 4;
  localparam int EXT_BIT = 0;
  localparam int D_BIT = 9;
  localparam int A_BIT = 8;

  // ---------------------------------------------------------------
  // Opcodes (instruction bits 15:10), addressing limits, resets
  // ---------------------------------------------------------------
  localparam logic [5:0] OPC_SUBB = 6'h16;
  localparam logic [5:0] OPC_SWAP = 6'h0e;
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [15:0] INSTR_RST = 16'h0000;

  // Execution phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } bsns_phase_e;

endpackage : bsns_pkg

// file: core/bsns_file_mem.sv
`timescale 1ns/100ps
module bsns_file_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [DW-1:0] wdata_in,
  // Read port
  input wire logic [AW-1:0] raddr_in,
  output logic [DW-1:0] rdata_out
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;

  // Read data settles one edge after the address
  always_comb
  begin
    rdata_next = mem[raddr_in];
  end

  // Storage write, no reset on the array
  always_ff @(posedge clk_in)
  begin
    if (we_in)
    begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // Registered read data
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_reg <= '0;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;

endmodule : bsns_file_mem

// file: core/bsns_alu.sv
`timescale 1ns/100ps
module bsns_alu (
  // Operation select
  input wire logic subb_in,
  // Operands
  input wire logic [7:0] file_in,
  input wire logic [7:0] w_in,
  input wire logic carry_in,
  // Results
  output logic [7:0] result_out,
  output logic [4:0] flags_out
);
  import bsns_pkg::*;

  logic [8:0] sum;
  logic [4:0] low;

  always_comb
  begin
    sum = {1'b0, file_in} + {1'b0, ~w_in} + {8'h00, carry_in};
    low = {1'b0, file_in[3:0]} + {1'b0, ~w_in[3:0]} + {4'h0, carry_in};
    flags_out = '0;
    flags_out[C_BIT] = sum[8];
    flags_out[DC_BIT] = low[4];
    flags_out[Z_BIT] = (sum[7:0] == 8'h00);
    flags_out[OV_BIT] = (file_in[7] ^ w_in[7]) & (file_in[7] ^ sum[7]);
    flags_out[N_BIT] = sum[7];
    result_out = subb_in ? sum[7:0] : {file_in[3:0], file_in[7:4]};
  end

endmodule : bsns_alu

// file: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import bsns_pkg::*;
  // ---------------------------------------------------------------
  // Signals and counters
  // ---------------------------------------------------------------
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [APB_AW-1:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic busy_out;
  int fail_count = 0;
  int total_checks = 0;

  // Free running 100 MHz clock
  always #5 clk_in = ~clk_in;

  bsns_core DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .busy_out(busy_out));

  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // Word compare
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  // Single bit compare
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // ---------------------------------------------------------------
  // APB master, holds the request until pready is seen
  // ---------------------------------------------------------------
  task automatic apb(input logic wr_en, input logic [7:0] addr,
    input logic [31:0] wdata, output logic [31:0] rdata, output logic err);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr_en;
    paddr_in <= addr;
    pwdata_in <= wdata;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    while (pready_out !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      fail_count++;
      complete_run();
    end
    rdata = prdata_out;
    err = pslverr_out;
    @(posedge clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  // Mapped write and read, no error expected
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk1(e, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk1(e, 1'b0);
  endtask : rd

  // ---------------------------------------------------------------
  // Expected values
  // ---------------------------------------------------------------
  function automatic logic [11:0] addr_of(logic a, logic [7:0] f,
    logic ext, logic [3:0] bank, logic [11:0] idx);
    if (a)
      return {bank, f};
    if (ext && f <= INDEX_LIMIT)
      return idx + {4'h0, f};
    if (f < ACCESS_SPLIT)
      return {4'h0, f};
    return {4'hf, f};
  endfunction : addr_of

  // Flags and result of file minus W minus inverted carry
  function automatic logic [12:0] sub_exp(logic [7:0] f, logic [7:0] w,
    logic [4:0] st);
    logic [8:0] d;
    logic [4:0] lo;
    logic [4:0] s;
    d = {1'b0, f} - {1'b0, w} - {8'h00, ~st[C_BIT]};
    lo = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, ~st[C_BIT]};
    s = 5'h00;
    s[C_BIT] = ~d[8];
    s[DC_BIT] = ~lo[4];
    s[Z_BIT] = (d[7:0] == 8'h00);
    s[OV_BIT] = (f[7] != w[7]) && (d[7] != f[7]);
    s[N_BIT] = d[7];
    return {s, d[7:0]};
  endfunction : sub_exp

  // ---------------------------------------------------------------
  // One instruction: preload, launch, check phases and results
  // ---------------------------------------------------------------
  task automatic run_op(logic sub, logic d, logic a, logic [7:0] f,
    logic [7:0] w, logic [4:0] st, logic ext, logic [3:0] bank,
    logic [11:0] idx, logic [7:0] m);
    logic [11:0] ad;
    logic [12:0] ex;
    logic [31:0] r;
    int cnt;
    ad = addr_of(a, f, ext, bank, idx);
    ex = sub ? sub_exp(m, w, st) : {st, m[3:0], m[7:4]};
    wr(CTRL_OFS, {31'h0, ext});
    wr(WREG_OFS, {24'h0, w});
    wr(BANK_OFS, {28'h0, bank});
    wr(IDX_OFS, {20'h0, idx});
    wr(MADDR_OFS, {20'h0, ad});
    wr(MDATA_OFS, {24'h0, m});
    wr(STATUS_OFS, {27'h0, st});
    wr(INSTR_OFS, {16'h0, sub ? OPC_SUBB : OPC_SWAP, d, a, f});
    cnt = 0;
    // Sample from the launch edge on, so the decode cycle is counted
    for (int i = 0; i < 8; i++)
    begin
      #1;
      if (busy_out === 1'b1)
        cnt++;
      @(posedge clk_in);
    end
    chk32(cnt, 32'd4);
    rd(WREG_OFS, r);
    chk32(r, {24'h0, d ? w : ex[7:0]});
    rd(STATUS_OFS, r);
    chk32(r, {27'h0, ex[12:8]});
    rd(MDATA_OFS, r);
    chk32(r, {24'h0, d ? ex[7:0] : m});
  endtask : run_op

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic e;
    logic [63:0] v;
    void'($urandom(41368));
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // Reset values
    rd(WREG_OFS, r);
    chk32(r, {24'h0, WREG_RST});
    rd(STATUS_OFS, r);
    chk32(r, {27'h0, STATUS_RST});
    rd(EXEC_OFS, r);
    chk32(r, 32'h0);
    $display("test reset done");
    // Unmapped places answer with an error
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk1(e, 1'b1);
    chk32(r, 32'h0);
    apb(1'b1, 8'hfc, 32'h1234, r, e);
    chk1(e, 1'b1);
    $display("test unmapped done");
    // Undefined opcode only raises the bad bit, nothing else moves
    wr(INSTR_OFS, 32'h0000_fc00);
    repeat (4) @(posedge clk_in);
    rd(EXEC_OFS, r);
    chk32(r, 32'h0000_0002);
    rd(WREG_OFS, r);
    chk32(r, {24'h0, WREG_RST});
    $display("test bad opcode done");
    // Reset in mid-run clears the bad bit and the registers
    wr(WREG_OFS, 32'h0000_00a5);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(EXEC_OFS, r);
    chk32(r, 32'h0);
    rd(WREG_OFS, r);
    chk32(r, {24'h0, WREG_RST});
    $display("test second reset done");
    // Worked cases, both destinations, boundaries of indexing
    run_op(1, 1, 0, 8'h10, 8'h0d, 5'h01, 0, 4'h0, 12'h0, 8'h19);
    run_op(1, 0, 0, 8'h20, 8'h1a, 5'h00, 0, 4'h0, 12'h0, 8'h1b);
    run_op(1, 1, 0, 8'h30, 8'h0e, 5'h01, 0, 4'h0, 12'h0, 8'h03);
    run_op(0, 1, 0, 8'h40, 8'h00, 5'h1f, 0, 4'h0, 12'h0, 8'h53);
    run_op(0, 0, 1, 8'h80, 8'h77, 5'h0a, 0, 4'h3, 12'h0, 8'hc4);
    run_op(1, 1, 0, 8'h5f, 8'h01, 5'h00, 1, 4'h0, 12'h2a0, 8'h80);
    run_op(1, 1, 0, 8'h60, 8'h7f, 5'h00, 1, 4'h0, 12'h2a0, 8'h00);
    run_op(0, 1, 0, 8'hf1, 8'h00, 5'h04, 0, 4'h0, 12'h0, 8'h0f);
    $display("test corners done");
    // Random operations
    for (int i = 0; i < 40; i++)
    begin
      v = {$urandom, $urandom};
      run_op(v[0], v[1], v[2], v[10:3], v[18:11], v[23:19], v[24],
        v[28:25], v[40:29], v[48:41]);
    end
    $display("test random done");
    complete_run();
  end

  // Watchdog against a hung transfer, well above the few thousand
  // cycles that the tests need
  initial
  begin
    #400000;
    fail_count++;
    complete_run();
  end
endmodule : tb
